// ==== timer_capture_compare_pwm_pkg.sv ====
// package of the capture/compare/pwm timer: register map, fields, state
// assumes a 32-bit classic wishbone slave port with byte addressing
package timer_capture_compare_pwm_pkg;
	localparam int NCH = 4;
	// ***************************************************************
	// register offsets
	// ***************************************************************
	localparam logic [5:0] ADR_CTRL   = 6'h00;
	localparam logic [5:0] ADR_CNT    = 6'h04;
	localparam logic [5:0] ADR_MOD    = 6'h08;
	localparam logic [5:0] ADR_CH0    = 6'h10;
	localparam logic [5:0] CH_STRIDE  = 6'h08;
	localparam logic [5:0] CH_VAL_OFS = 6'h04;
	// ***************************************************************
	// field positions
	// ***************************************************************
	localparam int CTRL_PS     = 0;
	localparam int CTRL_CLK    = 3;
	localparam int CTRL_CENTER = 5;
	localparam int CTRL_TOIE   = 6;
	localparam int CTRL_TOF    = 7;
	localparam int CSC_ELS     = 0;
	localparam int CSC_MS      = 2;
	localparam int CSC_IE      = 6;
	localparam int CSC_FLAG    = 7;
	localparam logic [15:0] CNT_TOP = 16'hFFFF;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	typedef enum logic [1:0] {CLK_OFF = 2'h0, CLK_BUS = 2'h1, CLK_FIXED = 2'h2, CLK_EXT = 2'h3} clk_src_t;
	typedef struct packed {
		logic [2:0]                ps;
		logic [1:0]                clkSel;
		logic                      center;
		logic                      tofIe;
		logic                      tof;
		logic [15:0]               cnt;
		logic [15:0]               modv;
		logic                      down;
		logic [6:0]                pre;
		logic [1:0]                fixSync;
		logic                      fixLast;
		logic [1:0]                extSync;
		logic                      extLast;
		logic [NCH-1:0][1:0]       els;
		logic [NCH-1:0][1:0]       msel;
		logic [NCH-1:0]            ie;
		logic [NCH-1:0]            flag;
		logic [NCH-1:0][15:0]      val;
		logic [NCH-1:0][2:0]       inSync;
		logic [NCH-1:0]            pinOut;
		logic [NCH-1:0]            pinOe;
		logic [NCH-1:0]            chIrq;
		logic                      tofIrq;
		logic                      ack;
		logic [31:0]               rdata;
	} state_t;
	// every control field resets to zero: timer off, prescale 1, modulo 0
	localparam state_t STATE_RST = '0;
endpackage : timer_capture_compare_pwm_pkg

// ==== timer_capture_compare_pwm.sv ====
// timer with 16-bit counter and capture/compare/pwm channels
// assumes synchronous inputs, one 20 MHz clock, classic wishbone master
//
// Summary of operation
// [R1] channels each capture, compare or edge pwm
// [R2] capture edge copies counter, sets flag
// [R3] compare match sets flag, drives pin action
// [R4] clock source bus, fixed or external pin
// [R5] prescale by 1 to 128 in powers
// [R6] fixed clock synchronised before counting
// [R7] 16-bit counter, up or up/down
// [R8] one request per channel plus overflow
// [R9] center bit forces center pwm everywhere
// [R10] debug mode freezes all counting
// [R11] keeps running in wait mode
// [R12] edge pwm period is modulo plus one
// [R13] edge pwm flags at period end, duty
// [R14] edge pwm leading edges at period start
// [R15] center pwm counts up then down
// [R16] center pwm set down-match, clear up-match
// [R17] modulo zero or all ones runs free
// [R18] counter reads do not disturb counting
// [R19] a counter write on either low byte lane clears the counter
// [R20] edge pwm high at zero, low at match
// [R21] capture inputs pass a clock synchroniser
// [R22] overflow flag sticky until software clears
//
// Chosen here: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module timer_capture_compare_pwm (
	input  wire logic                                        clk,
	input  wire logic                                        rst_n,
	input  wire logic                                        cyc_i,
	input  wire logic                                        stb_i,
	input  wire logic                                        we_i,
	input  wire logic [5:0]                                  adr_i,
	input  wire logic [3:0]                                  sel_i,
	input  wire logic [31:0]                                 dat_i,
	output logic      [31:0]                                 dat_o,
	output logic                                             ack_o,
	input  wire logic                                        debugActive,
	input  wire logic                                        fixedClkIn,
	input  wire logic                                        extClkIn,
	input  wire logic [timer_capture_compare_pwm_pkg::NCH-1:0] chIn,
	output logic      [timer_capture_compare_pwm_pkg::NCH-1:0] chOut,
	output logic      [timer_capture_compare_pwm_pkg::NCH-1:0] chOe,
	output logic      [timer_capture_compare_pwm_pkg::NCH-1:0] chIrq,
	output logic                                             tofIrq
);
	timer_capture_compare_pwm_pkg::state_t s;
	timer_capture_compare_pwm_pkg::state_t next_s;
	logic        tick;
	logic        stepUp;
	logic [15:0] nc;
	logic        wrAck;
	logic        req;

	assign req   = cyc_i & stb_i;
	assign wrAck = req & we_i & s.ack;

	// ***************************************************************
	// next state
	// ***************************************************************
	always_comb
	begin
		logic       srcTick;
		logic [6:0] mask;
		logic [15:0] lim;
		logic       tofSet;
		logic       rise;
		logic       fall;
		logic       match;
		logic [5:0] base;
		next_s  = s;
		srcTick = 1'b0;
		tofSet  = 1'b0;
		rise    = 1'b0;
		fall    = 1'b0;
		match   = 1'b0;
		base    = 6'h00;
		mask    = 7'h00;
		lim     = 16'h0000;
		stepUp  = 1'b1;
		nc      = s.cnt;
		// first stages feed only the second stages
		next_s.fixSync = {s.fixSync[0], fixedClkIn}; // [R6]
		next_s.fixLast = s.fixSync[1];
		next_s.extSync = {s.extSync[0], extClkIn};
		next_s.extLast = s.extSync[1];
		unique case (s.clkSel) // [R4]
			timer_capture_compare_pwm_pkg::CLK_BUS:   srcTick = 1'b1;
			timer_capture_compare_pwm_pkg::CLK_FIXED: srcTick = s.fixSync[1] & ~s.fixLast; // [R6]
			timer_capture_compare_pwm_pkg::CLK_EXT:   srcTick = s.extSync[1] & ~s.extLast;
			default:                                  srcTick = 1'b0;
		endcase
		// no wait-mode input exists, so counting simply continues there [R11]
		mask = 7'((8'h01 << s.ps) - 8'h01); // [R5]
		tick = srcTick & ~debugActive & ((s.pre & mask) == mask); // [R10]
		if (srcTick & ~debugActive)
		begin
			next_s.pre = s.pre + 7'h01; // [R5]
		end
		// ***********************************************************
		// main counter
		// ***********************************************************
		lim = ((s.modv == timer_capture_compare_pwm_pkg::CNT_ZERO) ||
			(s.modv == timer_capture_compare_pwm_pkg::CNT_TOP)) ?
			timer_capture_compare_pwm_pkg::CNT_TOP : s.modv; // [R17]
		if (tick)
		begin
			if (!s.center)
			begin
				if (s.cnt == lim) // [R7] [R12]
				begin
					nc     = timer_capture_compare_pwm_pkg::CNT_ZERO;
					tofSet = 1'b1; // [R13]
				end
				else
				begin
					nc = s.cnt + 16'h0001;
				end
			end
			else if (!s.down) // [R15]
			begin
				if (s.cnt == lim)
				begin
					nc            = s.cnt - 16'h0001;
					next_s.down   = 1'b1;
					stepUp        = 1'b0;
				end
				else
				begin
					nc = s.cnt + 16'h0001;
				end
			end
			else
			begin
				stepUp = 1'b0;
				if (s.cnt == timer_capture_compare_pwm_pkg::CNT_ZERO)
				begin
					nc          = 16'h0001;
					next_s.down = 1'b0;
					stepUp      = 1'b1;
				end
				else
				begin
					nc = s.cnt - 16'h0001;
					if (nc == timer_capture_compare_pwm_pkg::CNT_ZERO)
					begin
						next_s.down = 1'b0;
						tofSet      = 1'b1; // [R22]
					end
				end
			end
		end
		next_s.cnt = nc;
		// ***********************************************************
		// bus slave: ack one cycle after request, write at the ack edge
		// ***********************************************************
		next_s.ack   = req & ~s.ack;
		next_s.rdata = 32'h0000_0000;
		if (req & ~s.ack & ~we_i)
		begin
			// reads have no side effect on counting [R18]
			unique case (adr_i)
				timer_capture_compare_pwm_pkg::ADR_CTRL:
					next_s.rdata[7:0] = {s.tof, s.tofIe, s.center, s.clkSel, s.ps};
				timer_capture_compare_pwm_pkg::ADR_CNT: next_s.rdata[15:0] = s.cnt;
				timer_capture_compare_pwm_pkg::ADR_MOD: next_s.rdata[15:0] = s.modv;
				default: next_s.rdata = 32'h0000_0000;
			endcase
			for (int i = 0; i < timer_capture_compare_pwm_pkg::NCH; i++)
			begin
				base = 6'(timer_capture_compare_pwm_pkg::ADR_CH0 + 6'(i) * timer_capture_compare_pwm_pkg::CH_STRIDE);
				if (adr_i == base)
					next_s.rdata[7:0] = {s.flag[i], s.ie[i], 2'h0, s.msel[i], s.els[i]};
				if (adr_i == 6'(base + timer_capture_compare_pwm_pkg::CH_VAL_OFS))
					next_s.rdata[15:0] = s.val[i];
			end
		end
		if (wrAck)
		begin
			unique case (adr_i)
				timer_capture_compare_pwm_pkg::ADR_CTRL:
				begin
					if (sel_i[0])
					begin
						next_s.ps     = dat_i[timer_capture_compare_pwm_pkg::CTRL_PS +: 3];
						next_s.clkSel = dat_i[timer_capture_compare_pwm_pkg::CTRL_CLK +: 2];
						next_s.center = dat_i[timer_capture_compare_pwm_pkg::CTRL_CENTER];
						next_s.tofIe  = dat_i[timer_capture_compare_pwm_pkg::CTRL_TOIE];
						if (dat_i[timer_capture_compare_pwm_pkg::CTRL_TOF])
							next_s.tof = 1'b0;
					end
				end
				timer_capture_compare_pwm_pkg::ADR_CNT:
				begin
					if (sel_i[0] | sel_i[1]) // [R19]
					begin
						next_s.cnt  = timer_capture_compare_pwm_pkg::CNT_ZERO;
						next_s.pre  = 7'h00;
						next_s.down = 1'b0;
					end
				end
				timer_capture_compare_pwm_pkg::ADR_MOD:
				begin
					if (sel_i[0])
						next_s.modv[7:0] = dat_i[7:0];
					if (sel_i[1])
						next_s.modv[15:8] = dat_i[15:8];
				end
				default: ;
			endcase
			for (int i = 0; i < timer_capture_compare_pwm_pkg::NCH; i++)
			begin
				base = 6'(timer_capture_compare_pwm_pkg::ADR_CH0 + 6'(i) * timer_capture_compare_pwm_pkg::CH_STRIDE);
				if ((adr_i == base) && sel_i[0])
				begin
					next_s.els[i]  = dat_i[timer_capture_compare_pwm_pkg::CSC_ELS +: 2];
					next_s.msel[i] = dat_i[timer_capture_compare_pwm_pkg::CSC_MS +: 2];
					next_s.ie[i]   = dat_i[timer_capture_compare_pwm_pkg::CSC_IE];
					if (dat_i[timer_capture_compare_pwm_pkg::CSC_FLAG])
						next_s.flag[i] = 1'b0;
				end
				if (adr_i == 6'(base + timer_capture_compare_pwm_pkg::CH_VAL_OFS))
				begin
					if (sel_i[0])
						next_s.val[i][7:0] = dat_i[7:0];
					if (sel_i[1])
						next_s.val[i][15:8] = dat_i[15:8];
				end
			end
		end
		// sets come after the bus clears so a coincident event wins
		if (tofSet)
			next_s.tof = 1'b1; // [R22]
		// ***********************************************************
		// channels
		// ***********************************************************
		for (int i = 0; i < timer_capture_compare_pwm_pkg::NCH; i++)
		begin
			next_s.inSync[i] = {s.inSync[i][1:0], chIn[i]}; // [R21]
			rise  = s.inSync[i][1] & ~s.inSync[i][2];
			fall  = ~s.inSync[i][1] & s.inSync[i][2];
			match = tick & (nc == s.val[i]);
			if (s.center) // [R9]
			begin
				if (match && (s.els[i] != 2'h0))
				begin
					next_s.flag[i]   = 1'b1;
					// up-match deasserts, down-match asserts [R16]
					next_s.pinOut[i] = stepUp ? s.els[i][0] : ~s.els[i][0];
				end
			end
			else
			begin
				unique case (s.msel[i]) // [R1]
					2'h0:
					begin
						if ((s.els[i][0] & rise) | (s.els[i][1] & fall)) // [R2]
						begin
							next_s.val[i]  = s.cnt;
							next_s.flag[i] = 1'b1;
						end
					end
					2'h1:
					begin
						if (match) // [R3]
						begin
							next_s.flag[i] = 1'b1;
							unique case (s.els[i])
								2'h1:    next_s.pinOut[i] = ~s.pinOut[i];
								2'h2:    next_s.pinOut[i] = 1'b0;
								2'h3:    next_s.pinOut[i] = 1'b1;
								default: ;
							endcase
						end
					end
					default:
					begin
						// each edge pwm channel starts its pulse at count zero [R14]
						if (tick && (nc == timer_capture_compare_pwm_pkg::CNT_ZERO))
							next_s.pinOut[i] = ~s.els[i][0]; // [R20]
						if (match) // [R13]
						begin
							next_s.flag[i]   = 1'b1;
							next_s.pinOut[i] = s.els[i][0]; // [R20]
						end
					end
				endcase
			end
			next_s.pinOe[i] = (next_s.els[i] != 2'h0) &&
				(next_s.clkSel != timer_capture_compare_pwm_pkg::CLK_OFF) &&
				(next_s.center || (next_s.msel[i] != 2'h0));
			next_s.chIrq[i] = next_s.flag[i] & next_s.ie[i]; // [R8]
		end
		next_s.tofIrq = next_s.tof & next_s.tofIe; // [R8]
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			s <= timer_capture_compare_pwm_pkg::STATE_RST;
		else
			s <= next_s;
	end

	assign dat_o  = s.rdata;
	assign ack_o  = s.ack;
	assign chOut  = s.pinOut;
	assign chOe   = s.pinOe;
	assign chIrq  = s.chIrq;
	assign tofIrq = s.tofIrq;

	// ***************************************************************
	// assertions
	// ***************************************************************
	sequence s_cntWrite;
		wrAck && (adr_i == timer_capture_compare_pwm_pkg::ADR_CNT) && (sel_i[1:0] != 2'h0);
	endsequence

	property p_cntClear;
		@(posedge clk) disable iff (!rst_n) s_cntWrite |=> (s.cnt == 16'h0000) && !s.down;
	endproperty
	a_cntClear: assert property (p_cntClear) else $error("counter write did not clear it"); // [R19]

	property p_debugHold;
		@(posedge clk) disable iff (!rst_n) (debugActive && !wrAck) |=> (s.cnt == $past(s.cnt));
	endproperty
	a_debugHold: assert property (p_debugHold) else $error("counter moved in debug"); // [R10]

	property p_busDiv1;
		@(posedge clk) disable iff (!rst_n)
		(s.clkSel == timer_capture_compare_pwm_pkg::CLK_BUS && s.ps == 3'h0 && !s.center &&
		s.modv == 16'hFFFF && !debugActive && !wrAck) |=> (s.cnt == 16'($past(s.cnt) + 16'h0001));
	endproperty
	a_busDiv1: assert property (p_busDiv1) else $error("bus clock divide by one failed"); // [R5]

	property p_offStill;
		@(posedge clk) disable iff (!rst_n)
		(s.clkSel == timer_capture_compare_pwm_pkg::CLK_OFF && !wrAck)[*2] |=> $stable(s.cnt);
	endproperty
	a_offStill: assert property (p_offStill) else $error("counter moved with clock off"); // [R4]

	property p_tofSticky;
		@(posedge clk) disable iff (!rst_n) (s.tof && !wrAck) |=> s.tof;
	endproperty
	a_tofSticky: assert property (p_tofSticky) else $error("overflow flag dropped"); // [R22]

	property p_wrapUp;
		@(posedge clk) disable iff (!rst_n)
		(tick && !s.center && s.cnt == s.modv && s.modv != 16'h0000 && !wrAck)
		|=> (s.cnt == 16'h0000) && s.tof ##1 s.tofIrq == s.tofIe;
	endproperty
	a_wrapUp: assert property (p_wrapUp) else $error("modulo wrap wrong"); // [R7]

	property p_turnDown;
		@(posedge clk) disable iff (!rst_n)
		(tick && s.center && !s.down && s.cnt == s.modv && s.modv != 16'h0000 &&
		s.modv != 16'hFFFF && !wrAck) |=> s.down && (s.cnt == 16'($past(s.cnt) - 16'h0001));
	endproperty
	a_turnDown: assert property (p_turnDown) else $error("center count did not turn"); // [R15]

	property p_capture;
		@(posedge clk) disable iff (!rst_n)
		(!s.center && s.msel[1] == 2'h0 && s.els[1] == 2'h1 && s.inSync[1][1] && !s.inSync[1][2] && !wrAck)
		|=> s.flag[1] && (s.val[1] == $past(s.cnt));
	endproperty
	a_capture: assert property (p_capture) else $error("capture missed"); // [R2]

	property p_epwmStart;
		@(posedge clk) disable iff (!rst_n)
		(!s.center && s.msel[2][1] && s.els[2] == 2'h2 && tick && nc == 16'h0000 &&
		s.val[2] != 16'h0000) |=> s.pinOut[2] ##1 s.pinOe[2] || wrAck;
	endproperty
	a_epwmStart: assert property (p_epwmStart) else $error("pwm pin not high at period start"); // [R20]
endmodule : timer_capture_compare_pwm

// ==== pin_partner.sv ====
// model of what hangs on the channel pins: a source driving each pin
// assumes the bench sets the source level; the timer wins while it drives
`timescale 1ns/1ps
module pin_partner (
	input  wire logic [timer_capture_compare_pwm_pkg::NCH-1:0] chOut,
	input  wire logic [timer_capture_compare_pwm_pkg::NCH-1:0] chOe,
	input  wire logic [timer_capture_compare_pwm_pkg::NCH-1:0] drive,
	output logic      [timer_capture_compare_pwm_pkg::NCH-1:0] chIn
);
	// the source is weak: a driven pin shows the timer level, not a fight
	assign chIn = (chOe & chOut) | (~chOe & drive);
endmodule : pin_partner

// ==== testbench.sv ====
// self-checking bench of the capture/compare/pwm timer
// assumes the design package, the design and pin_partner compiled before
`timescale 1ns/1ps
module testbench;
	logic        clk      = 1'b0;
	logic        rst_n    = 1'b0;
	logic        cyc      = 1'b0;
	logic        stb      = 1'b0;
	logic        we       = 1'b0;
	logic [5:0]  adr      = 6'h00;
	logic [3:0]  sel      = 4'h0;
	logic [31:0] wdat     = 32'h0;
	logic [31:0] rdat;
	logic        ack;
	logic        dbg      = 1'b0;
	logic        fixClk   = 1'b0;
	logic        extClk   = 1'b0;
	logic [3:0]  pinDrive = 4'h0;
	logic [3:0]  chIn;
	logic [3:0]  chOut;
	logic [3:0]  chOe;
	logic [3:0]  chIrq;
	logic        tofIrq;
	logic [31:0] q;
	logic [31:0] a;
	int          err_total = 0;
	int          n_checks  = 0;
	localparam logic [5:0] CT = timer_capture_compare_pwm_pkg::ADR_CTRL;
	localparam logic [5:0] CN = timer_capture_compare_pwm_pkg::ADR_CNT;
	localparam logic [5:0] MD = timer_capture_compare_pwm_pkg::ADR_MOD;

	always #25 clk = ~clk;
	// slow sources stay well under a quarter of the bus clock
	always #200 fixClk = ~fixClk;
	always #400 extClk = ~extClk;

	timer_capture_compare_pwm i_timer_capture_compare_pwm (
		.clk(clk), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
		.dat_i(wdat), .dat_o(rdat), .ack_o(ack), .debugActive(dbg), .fixedClkIn(fixClk),
		.extClkIn(extClk), .chIn(chIn), .chOut(chOut), .chOe(chOe), .chIrq(chIrq), .tofIrq(tofIrq)
	);
	pin_partner i_pin_partner (.chOut(chOut), .chOe(chOe), .drive(pinDrive), .chIn(chIn));

	// ****************************************************************
	// bus and check helpers
	// ****************************************************************
	task bus(input logic w, input logic [5:0] ad, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= ad;
		wdat <= d;
		sel <= s;
		// a missing answer is left to the watchdog
		do
		begin
			@(posedge clk);
		end
		while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : bus

	task wr(input logic [5:0] ad, input logic [31:0] d);
		bus(1'b1, ad, d, 4'hF);
	endtask : wr

	task rd(input logic [5:0] ad);
		bus(1'b0, ad, 32'h0, 4'hF);
	endtask : rd

	task chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi, input string m);
		n_checks++;
		if (((got >= lo) && (got <= hi)) !== 1'b1)
		begin
			err_total++;
			$display("BAD %0t %s: got %h want %h..%h", $time, m, got, lo, hi);
		end
	endtask : chk

	function automatic logic [5:0] cha(input int n, input bit v);
		return timer_capture_compare_pwm_pkg::ADR_CH0 + timer_capture_compare_pwm_pkg::CH_STRIDE * 6'(n)
			+ (v ? timer_capture_compare_pwm_pkg::CH_VAL_OFS : 6'h00);
	endfunction : cha

	task freeze(input logic f);
		@(posedge clk);
		dbg <= f;
	endtask : freeze

	task highs(input int ch, input int n, output logic [31:0] h);
		h = 32'h0;
		repeat (n)
		begin
			@(posedge clk);
			h = h + 32'(chOut[ch]);
		end
	endtask : highs

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task t_reset();
		rd(CT);
		chk(q, 32'h0, 32'h0, "control after reset");
		wr(6'h0C, 32'hFFFF);
		rd(6'h0C);
		chk(q, 32'h0, 32'h0, "unmapped read");
		chk(32'(chOe), 32'h0, 32'h0, "pins released after reset");
	endtask : t_reset

	task t_count();
		wr(CT, 32'h08);
		rd(CN);
		a = q;
		rd(CN);
		chk(q - a, 32'h1, 32'h8, "count advance between reads");
		bus(1'b1, CN, 32'hFFFF, 4'h2);
		rd(CN);
		chk(q, 32'h0, 32'h8, "count cleared by high lane write");
		freeze(1'b1);
		rd(CN);
		a = q;
		repeat (20) @(posedge clk);
		rd(CN);
		chk(q, a, a, "count held in debug");
		freeze(1'b0);
	endtask : t_count

	task t_measure(input logic [31:0] ctl, input int div);
		wr(CT, ctl);
		wr(CN, 32'h0);
		repeat (512) @(posedge clk);
		rd(CN);
		chk(q, 32'(512 / div - 1), 32'(520 / div + 1), "count rate");
	endtask : t_measure

	task t_clocks();
		for (int p = 0; p < 8; p++)
		begin
			t_measure(32'h08 | 32'(p), 1 << p);
		end
		t_measure(32'h10, 8);
		t_measure(32'h18, 16);
	endtask : t_clocks

	task t_overflow();
		wr(MD, 32'h9);
		wr(CT, 32'h48);
		wr(CN, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			rd(CN);
			chk(q, 32'h0, 32'h9, "count within modulo");
		end
		chk(32'(tofIrq), 32'h1, 32'h1, "overflow request");
		freeze(1'b1);
		rd(CT);
		chk(32'(q[7]), 32'h1, 32'h1, "overflow flag kept");
		wr(CT, 32'hC8);
		rd(CT);
		chk(32'(q[7]), 32'h0, 32'h0, "overflow flag cleared");
		chk(32'(tofIrq), 32'h0, 32'h0, "overflow request gone");
		freeze(1'b0);
		wr(MD, 32'hFFFF);
		wr(CN, 32'h0);
		repeat (40) @(posedge clk);
		rd(CN);
		chk(q, 32'd40, 32'd48, "all ones modulo runs free");
	endtask : t_overflow

	task t_compare();
		int els[4] = '{0, 3, 2, 1};
		int pin[4] = '{0, 1, 0, 1};
		wr(MD, 32'h0);
		wr(CT, 32'h08);
		wr(cha(0, 1), 32'd200);
		for (int i = 0; i < 4; i++)
		begin
			wr(cha(0, 0), 32'h44 | 32'(els[i]));
			wr(CN, 32'h0);
			repeat (250) @(posedge clk);
			rd(cha(0, 0));
			chk(32'(q[7]), 32'h1, 32'h1, "compare flag");
			chk(32'(chIrq[0]), 32'h1, 32'h1, "channel request");
			chk(32'(chOe[0]), 32'(els[i] != 0), 32'(els[i] != 0), "compare drive");
			if (els[i] != 0)
				chk(32'(chOut[0]), 32'(pin[i]), 32'(pin[i]), "compare pin action");
			wr(cha(0, 0), 32'hC4 | 32'(els[i]));
		end
		wr(cha(0, 0), 32'h0);
	endtask : t_compare

	task t_capture();
		wr(cha(1, 0), 32'h01);
		freeze(1'b1);
		rd(CN);
		a = q;
		@(posedge clk);
		pinDrive[1] <= 1'b1;
		// four bus cycles is the shortest pulse that must be seen
		repeat (4) @(posedge clk);
		pinDrive[1] <= 1'b0;
		repeat (8) @(posedge clk);
		rd(cha(1, 1));
		chk(q, a, a, "captured count");
		wr(cha(1, 0), 32'h82);
		@(posedge clk);
		pinDrive[1] <= 1'b1;
		repeat (8) @(posedge clk);
		rd(cha(1, 0));
		chk(32'(q[7]), 32'h0, 32'h0, "rising ignored when falling chosen");
		@(posedge clk);
		pinDrive[1] <= 1'b0;
		repeat (8) @(posedge clk);
		rd(cha(1, 0));
		chk(32'(q[7]), 32'h1, 32'h1, "falling edge captured");
		freeze(1'b0);
		wr(cha(1, 0), 32'h0);
	endtask : t_capture

	task t_pwm();
		logic [31:0] h;
		wr(MD, 32'h9);
		wr(CT, 32'h08);
		// a count already above the new modulo would run on to the top first
		wr(CN, 32'h0);
		wr(cha(2, 1), 32'h3);
		for (int e = 2; e > 0; e--)
		begin
			wr(cha(2, 0), 32'h08 | 32'(e));
			repeat (20) @(posedge clk);
			highs(2, 100, h);
			chk(h, (e == 2) ? 32'd30 : 32'd70, (e == 2) ? 32'd30 : 32'd70, "edge pwm duty");
		end
		rd(cha(2, 0));
		chk(32'(q[7]), 32'h1, 32'h1, "duty point flag");
		rd(CT);
		chk(32'(q[7]), 32'h1, 32'h1, "period end flag");
		wr(CT, 32'h28);
		wr(MD, 32'h8);
		wr(CN, 32'h0);
		wr(cha(3, 1), 32'h3);
		wr(cha(3, 0), 32'h02);
		repeat (40) @(posedge clk);
		chk(32'(chOe[3]), 32'h1, 32'h1, "center drives capture channel");
		highs(3, 160, h);
		chk(h, 32'd60, 32'd60, "center pwm active span");
		highs(2, 160, h);
		chk(h, 32'd100, 32'd100, "center pwm low-true span");
	endtask : t_pwm

	// ****************************************************************
	// run control
	// ****************************************************************
	task close_out();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out

	initial
	begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_count();
		t_clocks();
		t_overflow();
		t_compare();
		t_capture();
		t_pwm();
		close_out();
	end

	// the scenarios need under ten thousand cycles
	initial
	begin
		#(20000 * 50);
		err_total++;
		$display("BAD %0t watchdog expired", $time);
		close_out();
	end
endmodule : testbench
